// ### pkg/dpub_pkg.sv
package dpub_pkg;
  // Unlock sequence bytes
  localparam logic [7:0] AUTOBAUD_BYTE = 8'h80;
  localparam logic [7:0] KEY_BYTE0     = 8'heb;
  localparam logic [7:0] KEY_BYTE1     = 8'h5a;
  localparam logic [7:0] KEY_BYTE2     = 8'h70;
  localparam logic [7:0] KEY_BYTE3     = 8'hcd;
  localparam int         KEY_LEN       = 4;
  // Instruction codes
  localparam logic [7:0] BRK_OPCODE    = 8'h00;
  localparam logic [7:0] ERASED_OPCODE = 8'hff;
  // Debugger control value that enters debug mode
  localparam logic [7:0] DBGCTL_ENTER  = 8'h80;
  // Break detection: low-bit count at the current bit time
  localparam int         BRK_BITS      = 10;
  // Clock and host wait time
  localparam int         CLK_MHZ       = 20;
  localparam int         RST_WAIT_MS   = 5;
  localparam int         RST_WAIT_CYC  = RST_WAIT_MS * 1000 * CLK_MHZ;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} dpub_rx_t;
endpackage

// ### hdl/dpub_top.sv
`timescale 1ns/1ns
module dpub_top (
  // Clock, enable, reset
  input  wire logic       mclk,
  input  wire logic       clk_en,
  input  wire logic       rstn,
  // Shared reset pin level, low holds the system in reset
  input  wire logic       shared_reset_pin_n,
  // Shared debug/GPIO pin
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  // GPIO side
  input  wire logic       gpio_out,
  input  wire logic       gpio_oe,
  output logic            gpio_in,
  // Debugger serial side
  input  wire logic       dbg_tx,
  output logic            dbg_rx,
  input  wire logic       dbg_ctl_wr,
  input  wire logic [7:0] dbg_ctl_data,
  output logic            dbg_break_ff,
  // CPU side
  input  wire logic       cpu_decode,
  input  wire logic [7:0] cpu_opcode,
  input  wire logic       bp_enable,
  output logic            cpu_idle_ff,
  output logic            cpu_nop_ff,
  // Status
  output logic            unlocked_ff,
  output logic            debug_mode_ff,
  output logic            limbo_ff
);

  logic [15:0] bit_cnt_ff;
  logic [15:0] bit_len_ff;
  logic [15:0] low_cnt_ff;
  logic [3:0]  bitn_ff;
  logic [7:0]  shf_ff;
  logic        rx_in_ff;
  logic        byte_vld_ff;
  logic [7:0]  byte_ff;
  logic [2:0]  seq_ff;
  logic        abandon_ff;
  logic        key_ok_ff;
  logic        in_rst_ff;
  dpub_pkg::dpub_rx_t rx_st_ff;

  // Debug function active on the shared pin
  wire dbg_active = unlocked_ff & ~in_rst_ff;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_in_ff  <= 1'b1;
      in_rst_ff <= 1'b1;
    end else if (clk_en) begin
      rx_in_ff  <= pin_in;
      in_rst_ff <= ~shared_reset_pin_n;
    end
  end

  // Pin mux: GPIO unless unlocked and out of reset; open-drain when debugging
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
      gpio_in <= 1'b1;
      dbg_rx  <= 1'b1;
    end else if (clk_en) begin
      if (dbg_active) begin
        pin_out <= 1'b0;
        pin_oe  <= ~dbg_tx;
        gpio_in <= 1'b1;
        dbg_rx  <= pin_in;
      end else begin
        pin_out <= gpio_out;
        pin_oe  <= gpio_oe;
        gpio_in <= pin_in;
        dbg_rx  <= 1'b1;
      end
    end
  end

  // Autobaud-measured byte receiver for the unlock key
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_st_ff    <= dpub_pkg::ST_IDLE;
      bit_cnt_ff  <= 16'h0000;
      bit_len_ff  <= 16'h0000;
      bitn_ff     <= 4'h0;
      shf_ff      <= 8'h00;
      byte_vld_ff <= 1'b0;
      byte_ff     <= 8'h00;
    end else if (clk_en) begin
      byte_vld_ff <= 1'b0;
      case (rx_st_ff)
        dpub_pkg::ST_IDLE: begin
          bit_cnt_ff <= 16'h0000;
          if (!rx_in_ff && in_rst_ff) begin
            rx_st_ff <= dpub_pkg::ST_START;
          end
        end
        dpub_pkg::ST_START: begin
          bit_cnt_ff <= bit_cnt_ff + 16'h0001;
          if (rx_in_ff) begin
            // Autobaud 80H: start plus seven zero bits low; first byte sets rate
            if (seq_ff == 3'h0) begin
              bit_len_ff <= bit_cnt_ff >> 3;
              rx_st_ff   <= dpub_pkg::ST_STOP;
            end else begin
              rx_st_ff <= dpub_pkg::ST_IDLE;
            end
          end else if (seq_ff != 3'h0 && bit_cnt_ff == (bit_len_ff >> 1)) begin
            bit_cnt_ff <= 16'h0000;
            bitn_ff    <= 4'h0;
            rx_st_ff   <= dpub_pkg::ST_DATA;
          end
        end
        dpub_pkg::ST_DATA: begin
          bit_cnt_ff <= bit_cnt_ff + 16'h0001;
          if (bit_cnt_ff == bit_len_ff) begin
            bit_cnt_ff <= 16'h0000;
            shf_ff     <= {rx_in_ff, shf_ff[7:1]};
            bitn_ff    <= bitn_ff + 4'h1;
            if (bitn_ff == 4'h7) begin
              byte_ff     <= {rx_in_ff, shf_ff[7:1]};
              byte_vld_ff <= 1'b1;
              rx_st_ff    <= dpub_pkg::ST_STOP;
            end
          end
        end
        dpub_pkg::ST_STOP: begin
          if (rx_in_ff) begin
            rx_st_ff <= dpub_pkg::ST_IDLE;
          end
        end
        default: rx_st_ff <= dpub_pkg::ST_IDLE;
      endcase
    end
  end

  // Key comparison in order
  logic [7:0] exp_byte;
  always_comb begin
    case (seq_ff)
      3'h1:    exp_byte = dpub_pkg::KEY_BYTE0;
      3'h2:    exp_byte = dpub_pkg::KEY_BYTE1;
      3'h3:    exp_byte = dpub_pkg::KEY_BYTE2;
      default: exp_byte = dpub_pkg::KEY_BYTE3;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      seq_ff     <= 3'h0;
      abandon_ff <= 1'b0;
      key_ok_ff  <= 1'b0;
    end else if (clk_en) begin
      if (!in_rst_ff) begin
        seq_ff     <= 3'h0;
        abandon_ff <= 1'b0;
        key_ok_ff  <= 1'b0;
      end else if (rx_st_ff == dpub_pkg::ST_START && rx_in_ff && seq_ff == 3'h0) begin
        seq_ff <= 3'h1;
      end else if (byte_vld_ff && !abandon_ff && !key_ok_ff) begin
        if (byte_ff != exp_byte) begin
          abandon_ff <= 1'b1;
        end else if (seq_ff == 3'(dpub_pkg::KEY_LEN)) begin
          key_ok_ff <= 1'b1;
        end else begin
          seq_ff <= seq_ff + 3'h1;
        end
      end
    end
  end

  // Unlock latch and limbo window
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      unlocked_ff <= 1'b0;
      limbo_ff    <= 1'b0;
    end else if (clk_en) begin
      if (in_rst_ff) begin
        unlocked_ff <= key_ok_ff;
        limbo_ff    <= key_ok_ff;
      end else begin
        limbo_ff <= 1'b0;
      end
    end
  end

  // Break detection on the pin, even while transmitting
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      low_cnt_ff   <= 16'h0000;
      dbg_break_ff <= 1'b0;
    end else if (clk_en) begin
      if (!dbg_active || rx_in_ff) begin
        low_cnt_ff   <= 16'h0000;
        dbg_break_ff <= 1'b0;
      end else if (bit_len_ff != 16'h0000 &&
                   low_cnt_ff == 16'(bit_len_ff * 16'(dpub_pkg::BRK_BITS))) begin
        dbg_break_ff <= 1'b1;
      end else begin
        low_cnt_ff <= low_cnt_ff + 16'h0001;
      end
    end
  end

  // Debug mode and breakpoint handling
  wire brk_hit = cpu_decode && cpu_opcode == dpub_pkg::BRK_OPCODE;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      debug_mode_ff <= 1'b0;
      cpu_idle_ff   <= 1'b0;
      cpu_nop_ff    <= 1'b0;
    end else if (clk_en) begin
      cpu_nop_ff <= brk_hit && !bp_enable;
      if (in_rst_ff) begin
        debug_mode_ff <= 1'b0;
        cpu_idle_ff   <= 1'b0;
      end else if (dbg_active && dbg_ctl_wr && dbg_ctl_data == dpub_pkg::DBGCTL_ENTER) begin
        debug_mode_ff <= 1'b1;
        cpu_idle_ff   <= 1'b1;
      end else if (brk_hit && bp_enable) begin
        debug_mode_ff <= 1'b1;
        cpu_idle_ff   <= 1'b1;
      end
    end
  end

  AST_NOP_WHEN_DISABLED:
    assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && brk_hit && !bp_enable && !debug_mode_ff |=> cpu_nop_ff && !cpu_idle_ff)
    else $error("disabled breakpoint did not act as no-op");
  AST_BRK_ENTERS_DEBUG:
    assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && brk_hit && bp_enable && !in_rst_ff |=> debug_mode_ff && cpu_idle_ff)
    else $error("enabled breakpoint did not enter debug");
  AST_GPIO_WHEN_LOCKED:
    assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && !unlocked_ff |=> pin_out == $past(gpio_out) && pin_oe == $past(gpio_oe))
    else $error("locked pin not driven as gpio");
  AST_UNLOCK_NEEDS_KEY:
    assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && $rose(unlocked_ff) |-> $past(key_ok_ff) && !$past(abandon_ff))
    else $error("unlock without full key");
  AST_OPEN_DRAIN:
    assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && dbg_active |=> pin_out == 1'b0)
    else $error("debug pin driven high");
  AST_LIMBO_OUT_DEBUG:
    assert property (@(posedge mclk) disable iff (!rstn)
      limbo_ff |-> !debug_mode_ff)
    else $error("limbo overlaps debug mode");
  AST_ABANDON_STICKS:
    assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && abandon_ff && in_rst_ff |=> abandon_ff && !key_ok_ff)
    else $error("abandoned unlock recovered");
  AST_BREAK_RESETS:
    assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && rx_in_ff |=> !dbg_break_ff)
    else $error("break held while line high");
endmodule

// ### sim/dpub_host.sv
`timescale 1ns/1ns
module dpub_host #(
  parameter int WAIT_CYC = 200,
  parameter int BIT_CYC  = 16
) (
  // Clock
  input  wire logic mclk,
  // High pulls the shared pin low
  output logic      drive_low
);
  initial drive_low = 1'b0;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic set_line(input logic low);
    drive_low = low;
  endtask

  // Scaled wait for the internal reset sequence
  task automatic wait_reset();
    tick(WAIT_CYC);
  endtask

  // One 8N1 frame, LSB first, at the autobaud rate
  task automatic send_byte(input logic [7:0] b);
    drive_low = 1'b1;
    tick(BIT_CYC);
    for (int i = 0; i < 8; i++) begin
      drive_low = ~b[i];
      tick(BIT_CYC);
    end
    drive_low = 1'b0;
    tick(BIT_CYC);
  endtask

  // Serial break, line held low for n bit times
  task automatic send_break(input int n);
    drive_low = 1'b1;
    tick(n * BIT_CYC);
    drive_low = 1'b0;
  endtask
endmodule

// ### sim/debug_pin_unlock_and_breakpoint_tb.sv
`timescale 1ns/1ns
module debug_pin_unlock_and_breakpoint_tb;
  typedef struct {string nm; logic e;} dpub_note_t;
  logic mclk, rstn, rst_pin_n, pin_in, pin_out, pin_oe, gpio_out, gpio_oe, gpio_in;
  logic dbg_tx, dbg_rx, ctl_wr, breakpoint_instruction, decode, bp_en, idle, no_operation, unl, dbg, limbo, low, en;
  logic [7:0] ctl_data, opcode;
  int   error_cnt, checks, cyc;
  dpub_note_t notes[$];
  event chk_ev;

  assign pin_in = ~low & (pin_oe ? pin_out : 1'b1);

  dpub_top dpub_top_i (.mclk(mclk), .clk_en(en), .rstn(rstn),
    .shared_reset_pin_n(rst_pin_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .dbg_tx(dbg_tx),
    .dbg_rx(dbg_rx), .dbg_ctl_wr(ctl_wr), .dbg_ctl_data(ctl_data), .dbg_break_ff(breakpoint_instruction),
    .cpu_decode(decode), .cpu_opcode(opcode), .bp_enable(bp_en), .cpu_idle_ff(idle),
    .cpu_nop_ff(no_operation), .unlocked_ff(unl), .debug_mode_ff(dbg), .limbo_ff(limbo));
  dpub_host dpub_host_i (.mclk(mclk), .drive_low(low));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  function automatic logic val_of(input string nm);
    case (nm)
      "unlocked": val_of = unl;
      "limbo":    val_of = limbo;
      "debug":    val_of = dbg;
      "idle":     val_of = idle;
      "nop":      val_of = no_operation;
      "break":    val_of = breakpoint_instruction;
      "pin_oe":   val_of = pin_oe;
      "pin_out":  val_of = pin_out;
      "gpio_in":  val_of = gpio_in;
      default:    val_of = dbg_rx;
    endcase
  endfunction

  task automatic expect_bit(input string nm, input logic e);
    notes.push_back('{nm, e});
    -> chk_ev;
    #1;
  endtask

  // Watcher takes every pending note, oldest first, and compares each with the output
  always @(chk_ev) begin
    while (notes.size() > 0) begin
      dpub_note_t n;
      n = notes.pop_front();
      checks++;
      if (val_of(n.nm) !== n.e) begin
        error_cnt++;
        $display("CHECK FAILED %s exp=%b got=%b", n.nm, n.e, val_of(n.nm));
      end
    end
  end

  task automatic summarize;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // Reset held, wait, autobaud, key with last byte k3
  task automatic unlock(input logic [7:0] k3);
    rst_pin_n = 1'b0;
    dpub_host_i.wait_reset();
    dpub_host_i.send_byte(dpub_pkg::AUTOBAUD_BYTE);
    dpub_host_i.send_byte(dpub_pkg::KEY_BYTE0);
    dpub_host_i.send_byte(dpub_pkg::KEY_BYTE1);
    dpub_host_i.send_byte(dpub_pkg::KEY_BYTE2);
    dpub_host_i.send_byte(k3);
    tick(4);
  endtask

  initial begin
    {rstn, gpio_out, gpio_oe, ctl_wr, decode, bp_en} = '0;
    {rst_pin_n, dbg_tx, en} = 3'b111;
    {ctl_data, opcode} = 16'hffff;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(8287));
    tick(10);
    rstn = 1'b1;
    tick(2);
    unlock(8'hce);
    expect_bit("unlocked", 1'b0);
    rst_pin_n = 1'b1;
    tick(4);
    expect_bit("unlocked", 1'b0);
    repeat (4) begin
      gpio_out = 1'($urandom);
      gpio_oe = 1'($urandom);
      tick(3);
      expect_bit("pin_oe", gpio_oe);
      if (gpio_oe === 1'b1) expect_bit("pin_out", gpio_out);
    end
    // Enable low freezes the pin mux
    gpio_oe = 1'b1;
    gpio_out = 1'b0;
    tick(2);
    en = 1'b0;
    gpio_out = 1'b1;
    tick(3);
    expect_bit("pin_out", 1'b0);
    en = 1'b1;
    tick(2);
    expect_bit("pin_out", 1'b1);
    gpio_oe = 1'b0;
    dpub_host_i.set_line(1'b1);
    tick(3);
    expect_bit("gpio_in", 1'b0);
    expect_bit("dbg_rx", 1'b1);
    dpub_host_i.set_line(1'b0);
    $display("test locked pin done");
    unlock(dpub_pkg::KEY_BYTE3);
    expect_bit("unlocked", 1'b1);
    expect_bit("limbo", 1'b1);
    expect_bit("debug", 1'b0);
    rst_pin_n = 1'b1;
    tick(4);
    expect_bit("limbo", 1'b0);
    dbg_tx = 1'b0;
    tick(3);
    expect_bit("pin_oe", 1'b1);
    expect_bit("pin_out", 1'b0);
    dbg_tx = 1'b1;
    dpub_host_i.set_line(1'b1);
    tick(3);
    expect_bit("pin_oe", 1'b0);
    expect_bit("dbg_rx", 1'b0);
    expect_bit("gpio_in", 1'b1);
    dpub_host_i.set_line(1'b0);
    bp_en = 1'b1;
    opcode = 8'($urandom_range(1, 255));
    decode = 1'b1;
    tick(1);
    decode = 1'b0;
    tick(2);
    expect_bit("debug", 1'b0);
    bp_en = 1'b0;
    opcode = dpub_pkg::BRK_OPCODE;
    decode = 1'b1;
    tick(1);
    decode = 1'b0;
    expect_bit("nop", 1'b1);
    tick(2);
    expect_bit("debug", 1'b0);
    dpub_host_i.send_byte(dpub_pkg::AUTOBAUD_BYTE);
    ctl_data = dpub_pkg::DBGCTL_ENTER;
    ctl_wr = 1'b1;
    tick(1);
    ctl_wr = 1'b0;
    tick(1);
    expect_bit("debug", 1'b1);
    $display("test unlock and control write done");
    rst_pin_n = 1'b0;
    tick(3);
    expect_bit("debug", 1'b0);
    unlock(dpub_pkg::KEY_BYTE3);
    rst_pin_n = 1'b1;
    tick(4);
    bp_en = 1'b1;
    decode = 1'b1;
    tick(1);
    decode = 1'b0;
    tick(2);
    expect_bit("debug", 1'b1);
    expect_bit("idle", 1'b1);
    dpub_host_i.send_break(12);
    expect_bit("break", 1'b1);
    tick(3);
    expect_bit("break", 1'b0);
    $display("test breakpoint and break done");
    summarize();
  end
endmodule
